// ==== hw/pin_sync.sv ====
// Purpose : Two-flop synchroniser for levels entering a clock domain.
// Assumes : Inputs are levels or slow toggles.
// Notes   : No reset; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input  wire logic             clock,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clock) begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule // pin_sync

`default_nettype wire

// ==== hw/result_fifo.sv ====
// Purpose : Synchronous FIFO with valid and ready on both sides.
// Assumes : One clock; synchronous active-low reset.
// Notes   : Flags are registered so in_ready and out_valid come from flops.
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_r  <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r  <= pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_r   <= count_nxt;
      in_ready  <= (count_nxt != FULL_C);
      out_valid <= (count_nxt != '0);
    end
  end

endmodule // result_fifo

`default_nettype wire

// ==== hw/result_mapper_params.svh ====
// Purpose : Constants for the result output pin mapper.
// Assumes : Included by bare name from the design files.
// Notes   : Widths, depths, reset values and counts live here.
`ifndef RESULT_MAPPER_PARAMS_SVH
`define RESULT_MAPPER_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define RES_BITS     18
`define PAIR_BITS    36
`define LINE_COUNT   16
`define FIFO_DEPTH   16

// ----------------------------------------------------------------
// Counts and reset values
// ----------------------------------------------------------------
`define PHASE_RST    2'h0
`define PHASE_LAST   2'h3
`define SER_LAST     5'h11
`define CNT_RST      5'h00

`endif

// ==== hw/result_mapper_pkg.sv ====
// Purpose : Types shared by the result output pin mapper.
// Assumes : Nothing beyond the constants header.
// Notes   : Enumerations carry no explicit codes.
package result_mapper_pkg;

  typedef enum logic {MODE_PARALLEL, MODE_SERIAL} link_mode_e;
  typedef enum logic {XS_IDLE, XS_SHIFT} xfer_state_e;
  typedef logic [35:0] pair_t;

endpackage

// ==== hw/result_output_pin_mapper.sv ====
// Purpose : Maps paired 18-bit results onto the shared output pins,
//           as a parallel bus or as two serial outputs.
// Assumes : host_clock runs free, at least four times the read or
//           serial clock rate; interface_select is static.
// Notes   : Each stream word holds the result for serial output A in
//           its upper half and for output B in its lower half.
`timescale 1ns/1ps
`default_nettype none
`include "result_mapper_params.svh"

module result_output_pin_mapper (
  // System clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Result stream
  input  wire logic                     result_valid,
  input  wire result_mapper_pkg::pair_t result_data,
  output logic                          result_ready,
  // Host link
  input  wire logic                     host_clock,
  input  wire logic                     chip_select_n,
  input  wire logic                     read_or_sclk,
  input  wire logic                     interface_select,
  // Output pins
  output logic [6:0]                    bus_lines_low,
  output logic [6:0]                    bus_lines_low_oe,
  output logic                          serial_out_a,
  output logic                          serial_out_a_oe,
  output logic                          serial_out_b,
  output logic                          serial_out_b_oe,
  output logic [4:0]                    bus_lines_upper_mid,
  output logic [4:0]                    bus_lines_upper_mid_oe,
  output logic                          bus_line_fourteen,
  output logic                          bus_line_fourteen_oe,
  output logic                          bus_line_fifteen,
  output logic                          bus_line_fifteen_oe,
  // Reference
  input  wire logic                     reference_select,
  output logic                          internal_reference_enable
);
  import result_mapper_pkg::*;

  // ----------------------------------------------------------------
  // System domain: buffer and word handoff
  // ----------------------------------------------------------------
  logic        fifo_valid;
  pair_t       fifo_data;
  logic        fifo_ready;
  logic        hand_fire;
  logic        req_r;
  logic        ack_s;
  logic        ref_s;
  logic        ref_en_r;
  pair_t       hold_r;
  logic        ack_r;

  result_fifo #(
    .WIDTH (`PAIR_BITS),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (result_valid),
    .in_data   (result_data),
    .in_ready  (result_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_ready)
  );

  pin_sync #(
    .WIDTH (2)
  ) u_sys_sync (
    .clock (clock),
    .d     ({reference_select, ack_r}),
    .q     ({ref_s, ack_s})
  );

  // Hold register stays still until the link has taken the word
  assign fifo_ready = (req_r == ack_s);
  assign hand_fire  = fifo_valid & fifo_ready;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      req_r    <= 1'b0;
      hold_r   <= '0;
      ref_en_r <= 1'b0;
    end else begin
      if (hand_fire) begin
        hold_r <= fifo_data;
        req_r  <= ~req_r;
      end
      ref_en_r <= ref_s;
    end
  end

  assign internal_reference_enable = ref_en_r;

  // ----------------------------------------------------------------
  // Link domain: synchronised pins
  // ----------------------------------------------------------------
  logic        link_rst_n;
  logic        cs_n_s;
  logic        rd_s;
  logic        sel_s;
  logic        req_s;

  pin_sync #(
    .WIDTH (5)
  ) u_link_sync (
    .clock (host_clock),
    .d     ({rst_n, chip_select_n, read_or_sclk, interface_select, req_r}),
    .q     ({link_rst_n, cs_n_s, rd_s, sel_s, req_s})
  );

  // ----------------------------------------------------------------
  // Link domain: decode
  // ----------------------------------------------------------------
  link_mode_e  mode;
  xfer_state_e xs_r;
  xfer_state_e xs_nxt;
  logic        is_serial;
  logic        cs_prev_r;
  logic        rd_prev_r;
  logic        loaded_r;
  logic [1:0]  phase_r;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  pair_t       pair_r;
  logic [17:0] sh_a_r;
  logic [17:0] sh_b_r;
  logic [17:0] sh_a_nxt;
  logic [17:0] sh_b_nxt;
  logic [17:0] half;
  logic [15:0] par_word;
  logic [15:0] line_out_r;
  logic [15:0] line_oe_r;
  logic [15:0] line_out_nxt;
  logic [15:0] line_oe_nxt;
  logic        par_active;
  logic        rd_rise;
  logic        par_pulse_end;
  logic        par_last;
  logic        cs_fall;
  logic        cs_rise;
  logic        req_pending;
  logic        quiet;
  logic        capture;
  logic        ser_load;
  logic        ser_shift;
  logic        ser_done;

  assign mode      = link_mode_e'(sel_s);
  assign is_serial = (mode == MODE_SERIAL);

  // drivers gated by select and read
  assign par_active    = !is_serial & !cs_n_s & !rd_s;
  assign rd_rise       = !cs_n_s & rd_s & !rd_prev_r;
  assign par_pulse_end = !is_serial & rd_rise;
  assign par_last      = par_pulse_end & (phase_r == `PHASE_LAST);
  assign cs_fall       = !cs_n_s & cs_prev_r;
  assign cs_rise       = cs_n_s & !cs_prev_r;
  assign req_pending   = req_s ^ ack_r;
  // New words only land between transfers, never mid-pulse
  assign quiet         = is_serial ? cs_n_s : rd_s;
  assign capture       = req_pending & !loaded_r & quiet
                       & (phase_r == `PHASE_RST) & (xs_r == XS_IDLE);
  assign ser_load      = is_serial & cs_fall & (xs_r == XS_IDLE);
  assign ser_shift     = is_serial & rd_rise & (xs_r == XS_SHIFT)
                       & (cnt_r < `SER_LAST);
  assign ser_done      = (xs_r == XS_SHIFT) & cs_rise;

  // first pulse upper bits, second low bits
  assign half     = phase_r[1] ? pair_r[17:0] : pair_r[35:18];
  assign par_word = phase_r[0] ? {half[1:0], 14'h0000} : half[17:2];

  // load on select fall, shift on clock rise
  always_comb begin
    sh_a_nxt = sh_a_r;
    sh_b_nxt = sh_b_r;
    cnt_nxt  = cnt_r;
    xs_nxt   = xs_r;
    case (xs_r)
      XS_IDLE: begin
        if (ser_load) begin
          sh_a_nxt = pair_r[35:18];
          sh_b_nxt = pair_r[17:0];
          cnt_nxt  = `CNT_RST;
          xs_nxt   = XS_SHIFT;
        end
      end
      XS_SHIFT: begin
        if (ser_done || !is_serial) begin
          xs_nxt = XS_IDLE;
        end else if (ser_shift) begin
          sh_a_nxt = {sh_a_r[16:0], 1'b0};
          sh_b_nxt = {sh_b_r[16:0], 1'b0};
          cnt_nxt  = cnt_r + 5'h01;
        end
      end
      default: begin
        xs_nxt = XS_IDLE;
      end
    endcase
  end

  // serial A on line seven; serial B on line eight
  // other lines stay undriven in serial mode
  assign line_out_nxt = is_serial
                      ? {7'h00, sh_b_nxt[17], sh_a_nxt[17], 7'h00}
                      : (par_active ? par_word : 16'h0000);
  assign line_oe_nxt  = is_serial
                      ? {7'h00, {2{!cs_n_s}}, 7'h00}
                      : {16{par_active}};

  // ----------------------------------------------------------------
  // Link domain: registers
  // ----------------------------------------------------------------
  always_ff @(posedge host_clock) begin
    if (!link_rst_n) begin
      cs_prev_r <= 1'b1;
      rd_prev_r <= 1'b1;
      ack_r     <= 1'b0;
      loaded_r  <= 1'b0;
      phase_r   <= `PHASE_RST;
      pair_r    <= '0;
    end else begin
      cs_prev_r <= cs_n_s;
      rd_prev_r <= rd_s;
      if (capture) begin
        pair_r   <= hold_r;
        loaded_r <= 1'b1;
        ack_r    <= ~ack_r;
      end else if (par_last) begin
        loaded_r <= 1'b0;
      end else if (ser_done && cnt_r == `SER_LAST) begin
        loaded_r <= 1'b0;
      end
      if (par_pulse_end) begin
        phase_r <= phase_r + 2'h1;
      end
    end
  end

  always_ff @(posedge host_clock) begin
    if (!link_rst_n) begin
      xs_r       <= XS_IDLE;
      cnt_r      <= `CNT_RST;
      sh_a_r     <= '0;
      sh_b_r     <= '0;
      line_out_r <= '0;
      line_oe_r  <= '0;
    end else begin
      xs_r       <= xs_nxt;
      cnt_r      <= cnt_nxt;
      sh_a_r     <= sh_a_nxt;
      sh_b_r     <= sh_b_nxt;
      line_out_r <= line_out_nxt;
      line_oe_r  <= line_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin mapping
  // ----------------------------------------------------------------
  // low lines carry bits eight to two
  assign bus_lines_low          = line_out_r[6:0];
  assign bus_lines_low_oe       = line_oe_r[6:0];
  assign serial_out_a           = line_out_r[7];
  assign serial_out_a_oe        = line_oe_r[7];
  assign serial_out_b           = line_out_r[8];
  assign serial_out_b_oe        = line_oe_r[8];
  // upper-mid lines carry bits fifteen to eleven
  assign bus_lines_upper_mid    = line_out_r[13:9];
  assign bus_lines_upper_mid_oe = line_oe_r[13:9];
  // line fourteen pairs bits sixteen and zero
  assign bus_line_fourteen      = line_out_r[14];
  assign bus_line_fourteen_oe   = line_oe_r[14];
  // line fifteen pairs bits seventeen and one
  assign bus_line_fifteen       = line_out_r[15];
  assign bus_line_fifteen_oe    = line_oe_r[15];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_par_bit_nine;
    @(posedge host_clock) disable iff (!link_rst_n)
    par_active && !phase_r[0] |=>
      serial_out_a_oe && (serial_out_a == $past(half[9]));
  endproperty
  a_par_bit_nine: assert property (p_par_bit_nine)
    else $error("line seven not bit nine on first pulse");

  property p_ser_out_a;
    @(posedge host_clock) disable iff (!link_rst_n)
    is_serial && !cs_n_s |=> serial_out_a_oe && (serial_out_a == sh_a_r[17]);
  endproperty
  a_ser_out_a: assert property (p_ser_out_a)
    else $error("serial output A not the shifter MSB");

  property p_par_bit_ten;
    @(posedge host_clock) disable iff (!link_rst_n)
    par_active && !phase_r[0] |=>
      serial_out_b_oe && (serial_out_b == $past(half[10]));
  endproperty
  a_par_bit_ten: assert property (p_par_bit_ten)
    else $error("line eight not bit ten on first pulse");

  property p_ser_b_idle;
    @(posedge host_clock) disable iff (!link_rst_n)
    is_serial && cs_n_s |=> !serial_out_b_oe;
  endproperty
  a_ser_b_idle: assert property (p_ser_b_idle)
    else $error("serial output B driven outside a frame");

  property p_mid_zero;
    @(posedge host_clock) disable iff (!link_rst_n)
    par_active && phase_r[0] |=>
      bus_lines_upper_mid_oe == 5'h1F && bus_lines_upper_mid == 5'h00;
  endproperty
  a_mid_zero: assert property (p_mid_zero)
    else $error("upper-mid lines not zero on second pulse");

  property p_line14;
    @(posedge host_clock) disable iff (!link_rst_n)
    par_active |=> bus_line_fourteen ==
      ($past(phase_r[0]) ? $past(half[0]) : $past(half[16]));
  endproperty
  a_line14: assert property (p_line14)
    else $error("line fourteen carries the wrong bit");

  property p_line15;
    @(posedge host_clock) disable iff (!link_rst_n)
    par_active |=> bus_line_fifteen ==
      ($past(phase_r[0]) ? $past(half[1]) : $past(half[17]));
  endproperty
  a_line15: assert property (p_line15)
    else $error("line fifteen carries the wrong bit");

  property p_ref;
    @(posedge clock) disable iff (!rst_n)
    ref_s ##1 ref_s |=> internal_reference_enable;
  endproperty
  a_ref: assert property (p_ref)
    else $error("internal reference not enabled");

  property p_pair_done;
    @(posedge host_clock) disable iff (!link_rst_n)
    par_last |=> !loaded_r && phase_r == `PHASE_RST;
  endproperty
  a_pair_done: assert property (p_pair_done)
    else $error("pair not retired after fourth pulse");

  property p_low_lines;
    @(posedge host_clock) disable iff (!link_rst_n)
    par_active |=> bus_lines_low ==
      ($past(phase_r[0]) ? 7'h00 : $past(half[8:2]));
  endproperty
  a_low_lines: assert property (p_low_lines)
    else $error("low lines carry the wrong bits");

  property p_par_off;
    @(posedge host_clock) disable iff (!link_rst_n)
    !is_serial && (cs_n_s || rd_s) |=> line_oe_r == 16'h0000;
  endproperty
  a_par_off: assert property (p_par_off)
    else $error("bus driven while not selected and reading");

  property p_shift;
    @(posedge host_clock) disable iff (!link_rst_n)
    ser_shift && !ser_done |=>
      sh_a_r == {$past(sh_a_r[16:0]), 1'b0} && cnt_r == $past(cnt_r) + 5'h01;
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial clock rise did not shift");

  property p_ser_quiet;
    @(posedge host_clock) disable iff (!link_rst_n)
    is_serial |=> !bus_line_fourteen_oe && !bus_line_fifteen_oe
      && bus_lines_low_oe == 7'h00 && bus_lines_upper_mid_oe == 5'h00;
  endproperty
  a_ser_quiet: assert property (p_ser_quiet)
    else $error("parallel-only line driven in serial mode");

  c_par_pair: cover property (@(posedge host_clock) disable iff (!link_rst_n)
    par_last);
  c_ser_frame: cover property (@(posedge host_clock)
    disable iff (!link_rst_n) ser_done && cnt_r == `SER_LAST);
  c_capture: cover property (@(posedge host_clock) disable iff (!link_rst_n)
    capture);
  c_fifo_full: cover property (@(posedge clock) disable iff (!rst_n)
    !result_ready);

endmodule // result_output_pin_mapper

`default_nettype wire

// ==== verification/host_model.sv ====
// Purpose : Host model that reads results over the shared pins.
// Assumes : Every phase lasts five link clock periods.
// Notes   : Strobe also pulses with select high when sel is 0; serial clock falls one phase before select.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // Link clock
  input  wire logic        host_clock,
  // Strobes to the device
  output logic             chip_select_n,
  output logic             read_or_sclk,
  // Pin lines as the host sees them
  input  wire logic [15:0] lines,
  input  wire logic [15:0] lines_oe
);
  localparam int PHASE = 5;

  logic [15:0] pins;

  // A released line reads inverted, so a late enable cannot pass unseen
  assign pins = (lines & lines_oe) | (~lines & ~lines_oe);

  initial begin
    chip_select_n = 1'b1;
    read_or_sclk  = 1'b1;
  end

  task automatic wait_phase();
    repeat (PHASE) @(posedge host_clock);
    #1;
  endtask

  task automatic read_pulse(input bit sel, output logic [15:0] val,
                            output logic [15:0] oe_on,
                            output logic [15:0] oe_off);
    @(posedge host_clock);
    #1;
    chip_select_n = !sel;
    read_or_sclk  = 1'b0;
    wait_phase();
    val          = pins;
    oe_on        = lines_oe;
    read_or_sclk = 1'b1;
    wait_phase();
    oe_off        = lines_oe;
    chip_select_n = 1'b1;
    // Strobe stays high long enough for the next pair to load
    wait_phase();
  endtask

  task automatic serial_frame(output logic [17:0] a,
                              output logic [17:0] b,
                              output logic [15:0] oe_seen,
                              output logic [1:0]  oe_end);
    oe_seen = 16'h0000;
    @(posedge host_clock);
    #1;
    read_or_sclk = 1'b0;
    wait_phase();
    chip_select_n = 1'b0;
    wait_phase();
    for (int i = 17; i >= 0; i--) begin
      a[i]    = pins[7];
      b[i]    = pins[8];
      oe_seen = oe_seen | lines_oe;
      if (i > 0) begin
        read_or_sclk = 1'b1;
        wait_phase();
        read_or_sclk = 1'b0;
        wait_phase();
      end
    end
    chip_select_n = 1'b1;
    wait_phase();
    oe_end = lines_oe[8:7];
  endtask
endmodule // host_model

`default_nettype wire

// ==== verification/result_output_pin_mapper_bench.sv ====
// Purpose : Self-checking bench for the result output pin mapper.
// Assumes : Mode changes only under reset.
// Notes   : Fill and drain run in parallel mode, one frame in serial.
`timescale 1ns/1ps
`default_nettype none
`include "result_mapper_params.svh"

module result_output_pin_mapper_bench;
  import result_mapper_pkg::*;

  logic        clock = 1'b0;
  logic        host_clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        result_valid = 1'b0;
  pair_t       result_data = 36'h0;
  logic        interface_select = 1'b0;
  logic        reference_select = 1'b0;
  logic        result_ready, chip_select_n, read_or_sclk;
  logic        internal_reference_enable;
  logic [6:0]  low_v, low_oe;
  logic [4:0]  mid_v, mid_oe;
  logic        a_v, a_oe, b_v, b_oe, l14_v, l14_oe, l15_v, l15_oe;
  logic [15:0] bus_val, bus_oe;
  int          n_mismatch = 0;
  int          checks_done = 0;

  assign bus_val = {l15_v, l14_v, mid_v, b_v, a_v, low_v};
  assign bus_oe  = {l15_oe, l14_oe, mid_oe, b_oe, a_oe, low_oe};

  always #2.5 clock = ~clock;
  always #40 host_clock = ~host_clock;

  result_output_pin_mapper DUT (
    .clock(clock), .rst_n(rst_n),
    .result_valid(result_valid), .result_data(result_data),
    .result_ready(result_ready),
    .host_clock(host_clock), .chip_select_n(chip_select_n),
    .read_or_sclk(read_or_sclk), .interface_select(interface_select),
    .bus_lines_low(low_v), .bus_lines_low_oe(low_oe),
    .serial_out_a(a_v), .serial_out_a_oe(a_oe),
    .serial_out_b(b_v), .serial_out_b_oe(b_oe),
    .bus_lines_upper_mid(mid_v), .bus_lines_upper_mid_oe(mid_oe),
    .bus_line_fourteen(l14_v), .bus_line_fourteen_oe(l14_oe),
    .bus_line_fifteen(l15_v), .bus_line_fifteen_oe(l15_oe),
    .reference_select(reference_select),
    .internal_reference_enable(internal_reference_enable)
  );

  host_model host (
    .host_clock(host_clock), .chip_select_n(chip_select_n),
    .read_or_sclk(read_or_sclk), .lines(bus_val), .lines_oe(bus_oe)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic pair_t word_of(input int k);
    return {18'h2AAAA ^ 18'(k), 18'h15555 ^ 18'(k * 37)};
  endfunction

  // Reset must also span four link clock edges
  task automatic do_reset(input logic sel);
    @(posedge clock);
    #1;
    rst_n            = 1'b0;
    interface_select = sel;
    repeat (20) @(posedge clock);
    repeat (4) @(posedge host_clock);
    @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge host_clock);
  endtask

  task automatic push(input pair_t w, output bit ok);
    int n;
    n  = 0;
    ok = 1'b0;
    @(posedge clock);
    #1;
    result_valid = 1'b1;
    result_data  = w;
    while (!ok && n < 40) begin
      ok = (result_ready === 1'b1);
      @(posedge clock);
      #1;
      n++;
    end
    result_valid = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    chk_val(36'(bus_oe), 36'h0);
    chk_flag(result_ready, 1'b1);
    chk_flag(internal_reference_enable, 1'b0);
    $display("test_reset done");
  endtask

  task automatic test_reference();
    for (int v = 1; v >= 0; v--) begin
      @(posedge clock);
      #1;
      reference_select = 1'(v);
      repeat (5) @(posedge clock);
      #1;
      chk_flag(internal_reference_enable, 1'(v));
    end
    $display("test_reference done");
  endtask

  task automatic test_parallel();
    logic [15:0] v, on, off, e;
    logic [17:0] h;
    pair_t       w;
    bit          ok;
    int          n;
    // Host stays idle so the FIFO fills behind the link register
    n  = 0;
    ok = 1'b1;
    while (ok && n < 40) begin
      push(word_of(n), ok);
      if (ok) n++;
    end
    // Link register and hold register each keep one word beyond the FIFO
    chk_val(36'(n), 36'(`FIFO_DEPTH + 2));
    chk_flag(result_ready, 1'b0);
    host.read_pulse(1'b0, v, on, off);
    chk_val(36'(on), 36'h0);
    for (int k = 0; k < n; k++) begin
      w = word_of(k);
      for (int p = 0; p < 4; p++) begin
        h = (p < 2) ? w[35:18] : w[17:0];
        e = (p % 2 == 0) ? h[17:2] : {h[1:0], 14'h0000};
        host.read_pulse(1'b1, v, on, off);
        chk_val(36'(v), 36'(e));
        chk_val(36'(on), 36'hFFFF);
        chk_val(36'(off), 36'h0);
      end
    end
    chk_flag(result_ready, 1'b1);
    $display("test_parallel done");
  endtask

  task automatic test_serial();
    logic [17:0] a, b;
    logic [15:0] seen;
    logic [1:0]  oe_end;
    pair_t       w;
    bit          ok;
    do_reset(1'b1);
    w = word_of(50);
    push(w, ok);
    chk_flag(ok, 1'b1);
    host.serial_frame(a, b, seen, oe_end);
    chk_val(36'(a), 36'(w[35:18]));
    chk_val(36'(b), 36'(w[17:0]));
    chk_val(36'(seen[8:7]), 36'h3);
    chk_val(36'(seen & 16'hFE7F), 36'h0);
    chk_val(36'(oe_end), 36'h0);
    $display("test_serial done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    do_reset(1'b0);
    test_reset();
    test_reference();
    test_parallel();
    test_serial();
    end_of_test();
  end

  // Tests need about 110 us; a hang is cut well beyond that
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
endmodule // result_output_pin_mapper_bench

`default_nettype wire
